/* core/sadc_pkg.sv */
`default_nettype none

package sadc_pkg;

    // Register byte offsets on the bus, one aligned word each.
    localparam logic [7:0] OFS_SCR  = 8'h00;
    localparam logic [7:0] OFS_HIGH = 8'h04;
    localparam logic [7:0] OFS_LOW  = 8'h08;
    localparam logic [7:0] OFS_CLK  = 8'h0C;

    // Fields of conv_status_control.
    localparam int SCR_FLAG = 7;
    localparam int SCR_IEN  = 6;
    localparam int SCR_CONT = 5;
    localparam int CH_HI    = 4;

    // Fields of conv_clock_format.
    localparam int CLK_DIV_HI = 7;
    localparam int CLK_DIV_LO = 5;
    localparam int CLK_SRC    = 4;
    localparam int CLK_MODE_HI = 3;
    localparam int CLK_MODE_LO = 2;

    // Reset values: converter off, crystal source, divide by one, right justified.
    localparam logic [7:0] SCR_RESET = 8'h1F;
    localparam logic [7:0] CLK_RESET = 8'h04;

    // Channel codes of note.
    localparam logic [4:0] CH_POWER_OFF = 5'h1F;
    localparam logic [4:0] CH_HIGH_REF  = 5'h1D;
    localparam logic [4:0] CH_GROUND    = 5'h1E;
    localparam logic [4:0] CH_FACTORY   = 5'h1B;

    // Result formats of the justification field.
    localparam logic [1:0] MODE_TRUNC  = 2'h0;
    localparam logic [1:0] MODE_RIGHT  = 2'h1;
    localparam logic [1:0] MODE_LEFT   = 2'h2;
    localparam logic [1:0] MODE_SIGNED = 2'h3;

    // Sampling ticks, the first of them partial, then one tick per result bit.
    localparam int          RES_BITS     = 10;
    localparam logic [3:0]  SAMPLE_TICKS = 4'h7;
    localparam logic [3:0]  MSB_INDEX    = 4'h9;

    // Converter sequencer, Gray coded along idle, sample, convert, done.
    typedef enum logic [1:0] {
        SADC_IDLE    = 2'h0,
        SADC_SAMPLE  = 2'h1,
        SADC_CONVERT = 2'h3,
        SADC_DONE    = 2'h2
    } sadc_state_t;

endpackage : sadc_pkg

`default_nettype wire

/* core/sadc_clkdiv.sv */
`default_nettype none

module sadc_clkdiv
    import sadc_pkg::*;
(
    input  wire logic       clk,             // Bus clock.
    input  wire logic       rst_n,           // Asynchronous reset, active low.
    input  wire logic       crystal_clock,   // Crystal clock level, synchronous sample.
    input  wire logic       input_clock_select, // 1 bus clock, 0 crystal clock.
    input  wire logic [2:0] clock_prescaler, // Divide ratio code.
    output logic            conv_tick        // One-cycle pulse per converter clock.
);

    typedef struct packed {
        logic       xtal_prev;
        logic [3:0] cnt;
        logic       tick;
    } sadc_div_t;

    sadc_div_t s;
    sadc_div_t next_s;

    // Terminal count for each prescaler code; the top bit forces divide by 16.
    function automatic logic [3:0] div_last(input logic [2:0] code);
        if (code[2])
            return 4'hF;
        else if (code == 3'h3)
            return 4'h7;
        else if (code == 3'h2)
            return 4'h3;
        else if (code == 3'h1)
            return 4'h1;
        else
            return 4'h0;
    endfunction : div_last

    // Input ticks come from every bus cycle or from each crystal rising edge.
    always_comb
    begin
        logic in_tick;
        in_tick = input_clock_select | (crystal_clock & ~s.xtal_prev);
        next_s = s;
        next_s.xtal_prev = crystal_clock;
        next_s.tick = 1'b0;
        if (in_tick)
        begin
            if (s.cnt >= div_last(clock_prescaler))
            begin
                next_s.cnt = 4'h0;
                next_s.tick = 1'b1;
            end
            else
            begin
                next_s.cnt = s.cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign conv_tick = s.tick;

    // Bus source at divide by one ticks on every cycle.
    property p_div_one;
        @(posedge clk) disable iff (!rst_n)
        (input_clock_select && clock_prescaler == 3'h0)[*2] |=> conv_tick;
    endproperty
    a_div_one: assert property (p_div_one) else $error("divide by one missed a tick");

endmodule : sadc_clkdiv

`default_nettype wire

/* core/sadc_ctrl.sv */
// The placing of the registers and the Wishbone register port are this design's own decisions.
`default_nettype none

module sadc_ctrl
    import sadc_pkg::*;
(
    input  wire logic        clk,            // Bus clock, 40 MHz.
    input  wire logic        rst_n,          // Asynchronous reset, active low.
    input  wire logic        wb_cyc_i,       // Wishbone cycle.
    input  wire logic        wb_stb_i,       // Wishbone strobe.
    input  wire logic        wb_we_i,        // Wishbone write enable.
    input  wire logic [7:0]  wb_adr_i,       // Wishbone byte address.
    input  wire logic [3:0]  wb_sel_i,       // Wishbone byte enables.
    input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
    output logic [31:0]      wb_dat_o,       // Wishbone read data.
    output logic             wb_ack_o,       // Wishbone acknowledge.
    input  wire logic        crystal_clock,  // Crystal clock level.
    input  wire logic        comp_in,        // Comparator: input at or above trial code.
    output logic [9:0]       dac_code,       // Trial code to the analog core.
    output logic [4:0]       sample_channel, // Channel routed to the analog core.
    output logic             sample_enable,  // Analog core is sampling.
    output logic             power_off,      // Analog core powered down.
    output logic             conv_irq        // Conversion interrupt request, high.
);

    typedef struct packed {
        logic [31:0]  rdata;
        logic         ack;
        logic [7:0]   scr;
        logic [7:0]   clkfmt;
        logic [7:0]   res_high;
        logic [7:0]   res_low;
        logic         frozen;
        logic         first_seen;
        logic         irq;
        sadc_state_t  state;
        logic [3:0]   cnt;
        logic [3:0]   bit_idx;
        logic [9:0]   trial;
        logic         sampling;
        logic         off;
    } sadc_ctrl_t;

    sadc_ctrl_t s;
    sadc_ctrl_t next_s;
    logic       conv_tick;
    logic       done_ev;
    logic       wr_scr;
    logic       rd_high;
    logic       rd_low;

    // Register index of a byte address; 0 means unmapped.
    function automatic logic [2:0] reg_sel(input logic [7:0] adr);
        if (adr == OFS_SCR)
            return 3'h1;
        else if (adr == OFS_HIGH)
            return 3'h2;
        else if (adr == OFS_LOW)
            return 3'h3;
        else if (adr == OFS_CLK)
            return 3'h4;
        else
            return 3'h0;
    endfunction : reg_sel

    sadc_clkdiv u_div (
        .clk                (clk),
        .rst_n              (rst_n),
        .crystal_clock      (crystal_clock),
        .input_clock_select (s.clkfmt[CLK_SRC]),
        .clock_prescaler    (s.clkfmt[CLK_DIV_HI:CLK_DIV_LO]),
        .conv_tick          (conv_tick)
    );

    // Bus decode; a request is taken on the edge where it is seen without ack.
    always_comb
    begin
        logic take;
        take = wb_cyc_i & wb_stb_i & ~s.ack;
        wr_scr = take & wb_we_i & wb_sel_i[0] & (reg_sel(wb_adr_i) == 3'h1);
        rd_high = take & ~wb_we_i & (reg_sel(wb_adr_i) == 3'h2);
        rd_low = take & ~wb_we_i & (reg_sel(wb_adr_i) == 3'h3);
    end

    assign done_ev = (s.state == SADC_DONE) & ~wr_scr;

    // Whole next state. Bus clears come before conversion sets so a completion
    // landing on a data read still raises the flag or interrupt; a control write aborts the
    // conversion, so its own completion is dropped along with it.
    always_comb
    begin
        logic       take;
        logic [9:0] r;
        logic [4:0] ch;
        take = wb_cyc_i & wb_stb_i & ~s.ack;
        r = s.trial;
        ch = wb_dat_i[CH_HI:0];
        next_s = s;
        next_s.ack = take;
        next_s.rdata = '0;

        // Read data and its side effects.
        if (take && !wb_we_i)
        begin
            if (reg_sel(wb_adr_i) == 3'h1)
                next_s.rdata[7:0] = s.scr;
            else if (reg_sel(wb_adr_i) == 3'h2)
                next_s.rdata[7:0] = s.res_high;
            else if (reg_sel(wb_adr_i) == 3'h3)
                next_s.rdata[7:0] = s.res_low;
            else if (reg_sel(wb_adr_i) == 3'h4)
                next_s.rdata[7:0] = s.clkfmt;
        end
        if (rd_high || rd_low)
        begin
            next_s.irq = 1'b0;
            if (!s.scr[SCR_IEN])
                next_s.scr[SCR_FLAG] = 1'b0;
        end
        if (rd_high && s.clkfmt[CLK_MODE_HI:CLK_MODE_LO] != MODE_TRUNC)
            next_s.frozen = 1'b1;
        if (rd_low)
            next_s.frozen = 1'b0;

        // Clock and format register is plain read and write.
        if (take && wb_we_i && wb_sel_i[0] && reg_sel(wb_adr_i) == 3'h4)
            next_s.clkfmt = wb_dat_i[7:0];

        if (wr_scr)
        begin
            next_s.scr[SCR_IEN:0] = wb_dat_i[SCR_IEN:0];
            // With interrupts on, the flag takes the written value.
            next_s.scr[SCR_FLAG] = wb_dat_i[SCR_IEN] & wb_dat_i[SCR_FLAG];
            next_s.irq = 1'b0;
            next_s.first_seen = 1'b0;
            next_s.cnt = 4'h0;
            next_s.trial = '0;
            if (ch == CH_POWER_OFF)
                next_s.state = SADC_IDLE;
            else
                next_s.state = SADC_SAMPLE;
        end
        else
        begin
            case (s.state)
                SADC_IDLE:
                begin
                    next_s.cnt = 4'h0;
                end
                SADC_SAMPLE:
                begin
                    // The first tick ends a partial cycle left by the write.
                    if (conv_tick)
                    begin
                        if (s.cnt == SAMPLE_TICKS - 4'h1)
                        begin
                            next_s.state = SADC_CONVERT;
                            next_s.bit_idx = MSB_INDEX;
                            next_s.trial = 10'h200;
                            next_s.cnt = 4'h0;
                        end
                        else
                        begin
                            next_s.cnt = s.cnt + 4'h1;
                        end
                    end
                end
                SADC_CONVERT:
                begin
                    // Keep or drop the trial bit, then try the next lower one.
                    if (conv_tick)
                    begin
                        next_s.trial[s.bit_idx] = comp_in;
                        if (s.bit_idx == 4'h0)
                            next_s.state = SADC_DONE;
                        else
                        begin
                            next_s.bit_idx = s.bit_idx - 4'h1;
                            next_s.trial[s.bit_idx - 4'h1] = 1'b1;
                        end
                    end
                end
                SADC_DONE:
                begin
                    // Results are dropped while result_low is frozen.
                    if (!s.frozen)
                    begin
                        case (s.clkfmt[CLK_MODE_HI:CLK_MODE_LO])
                            MODE_TRUNC:
                            begin
                                next_s.res_high = 8'h00;
                                next_s.res_low = r[9:2];
                            end
                            MODE_RIGHT:
                            begin
                                next_s.res_high = {6'h00, r[9:8]};
                                next_s.res_low = r[7:0];
                            end
                            MODE_LEFT:
                            begin
                                next_s.res_high = r[9:2];
                                next_s.res_low = {r[1:0], 6'h00};
                            end
                            default:
                            begin
                                next_s.res_high = {~r[9], r[8:2]};
                                next_s.res_low = {r[1:0], 6'h00};
                            end
                        endcase
                    end
                    if (s.scr[SCR_IEN])
                        next_s.irq = 1'b1;
                    else if (!s.scr[SCR_CONT] || !s.first_seen)
                        next_s.scr[SCR_FLAG] = 1'b1;
                    next_s.first_seen = 1'b1;
                    next_s.trial = '0;
                    if (s.scr[SCR_CONT])
                        next_s.state = SADC_SAMPLE;
                    else
                        next_s.state = SADC_IDLE;
                end
                default:
                begin
                    next_s.state = SADC_IDLE;
                end
            endcase
        end

        // Analog-side controls follow the next state so they leave flip-flops.
        next_s.off = (next_s.scr[CH_HI:0] == CH_POWER_OFF);
        next_s.sampling = (next_s.state == SADC_SAMPLE);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.scr <= SCR_RESET;
            s.clkfmt <= CLK_RESET;
            s.off <= 1'b1;
            s.state <= SADC_IDLE;
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register.
    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign dac_code = s.trial;
    assign sample_channel = s.scr[CH_HI:0];
    assign sample_enable = s.sampling;
    assign power_off = s.off;
    assign conv_irq = s.irq;

    // Named steps of a control write.
    sequence s_scr_write;
        wr_scr && !wb_dat_i[SCR_IEN];
    endsequence

    sequence s_run_write;
        wr_scr && wb_dat_i[CH_HI:0] != CH_POWER_OFF;
    endsequence

    property p_scr_clears_flag;
        @(posedge clk) disable iff (!rst_n)
        s_scr_write |=> !s.scr[SCR_FLAG] ##1 wb_ack_o == 1'b0;
    endproperty
    a_scr_clears_flag: assert property (p_scr_clears_flag) else $error("write left flag set");

    property p_restart;
        @(posedge clk) disable iff (!rst_n)
        s_run_write |=> s.state == SADC_SAMPLE && s.cnt == 4'h0 && sample_enable;
    endproperty
    a_restart: assert property (p_restart) else $error("write did not restart");

    property p_irq_set;
        @(posedge clk) disable iff (!rst_n)
        done_ev && s.scr[SCR_IEN] |=> conv_irq;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt not raised");

    property p_irq_clear;
        @(posedge clk) disable iff (!rst_n)
        rd_low && !done_ev |=> !conv_irq;
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

    property p_flag_set;
        @(posedge clk) disable iff (!rst_n)
        done_ev && !s.scr[SCR_IEN] && !s.scr[SCR_CONT] |=> s.scr[SCR_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set at end");

    property p_power_off;
        @(posedge clk) disable iff (!rst_n)
        s.scr[CH_HI:0] == CH_POWER_OFF |-> power_off && s.state != SADC_CONVERT;
    endproperty
    a_power_off: assert property (p_power_off) else $error("converter not off");

    property p_frozen;
        @(posedge clk) disable iff (!rst_n)
        done_ev && s.frozen |=> $stable(s.res_low) && $stable(s.res_high);
    endproperty
    a_frozen: assert property (p_frozen) else $error("frozen result overwritten");

    property p_single;
        @(posedge clk) disable iff (!rst_n)
        done_ev && !s.scr[SCR_CONT]
        |=> s.state == SADC_IDLE ##1 (s.state == SADC_IDLE || $past(wr_scr));
    endproperty
    a_single: assert property (p_single) else $error("single mode kept going");

    property p_right;
        @(posedge clk) disable iff (!rst_n)
        done_ev && !s.frozen && s.clkfmt[CLK_MODE_HI:CLK_MODE_LO] == MODE_RIGHT
        |=> s.res_high == {6'h00, $past(s.trial[9:8])} && s.res_low == $past(s.trial[7:0]);
    endproperty
    a_right: assert property (p_right) else $error("right justified format wrong");

    property p_last_bit;
        @(posedge clk) disable iff (!rst_n)
        s.state == SADC_CONVERT && s.bit_idx == 4'h0 && conv_tick && !wr_scr
        |=> s.state == SADC_DONE ##1 s.state != SADC_DONE;
    endproperty
    a_last_bit: assert property (p_last_bit) else $error("conversion length wrong");

endmodule : sadc_ctrl

`default_nettype wire

/* dv/sadc_analog_model.sv */
`default_nettype none

module sadc_analog_model
    import sadc_pkg::*;
(
    input  wire logic [9:0] dac_code,       // Trial code from the sequencer.
    input  wire logic [4:0] sample_channel, // Channel under conversion.
    input  wire logic [9:0] port_level,     // Level on every port channel.
    output logic            comp_in         // High when input reaches the trial code.
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] level;

    // Unused codes take the inverse of the trial code so that no fixed result can be trusted.
    always_comb
    begin
        if (sample_channel < 5'h07)
            level = port_level;
        else if (sample_channel == CH_HIGH_REF)
            level = 10'h3FF;
        else if (sample_channel == CH_GROUND)
            level = 10'h000;
        else
            level = ~dac_code;
    end

    // Ideal comparator with no settling time.
    assign comp_in = (level >= dac_code);

endmodule : sadc_analog_model

`default_nettype wire

/* dv/tb.sv */
`default_nettype none

module tb
    import sadc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_n, cyc, stb, we, crystal_clock, comp_in, ack;
    logic        sample_enable, power_off, conv_irq;
    logic [7:0]  adr, q;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat;
    logic [9:0]  dac_code, port_level;
    logic [4:0]  sample_channel;
    int          error_cnt, tests_run, n;

    sadc_ctrl DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .crystal_clock(crystal_clock),
        .comp_in(comp_in), .dac_code(dac_code), .sample_channel(sample_channel),
        .sample_enable(sample_enable), .power_off(power_off), .conv_irq(conv_irq));

    sadc_analog_model u_analog (.dac_code(dac_code), .sample_channel(sample_channel),
        .port_level(port_level), .comp_in(comp_in));

    // Bus clock at 40 MHz, crystal at 10 MHz with edges on bus falling edges, away from the rising ones.
    always #12.5 clk = ~clk;
    always #50 crystal_clock = ~crystal_clock;

    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask : chk8

    task automatic chkr(input string nm, input int lo, input int hi, input int v);
        tests_run++;
        if (v < lo || v > hi)
        begin
            $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, v);
            error_cnt++;
        end
    endtask : chkr

    // One classic cycle; ack is sampled at each rising edge and the request drops
    // right after the edge that sees it, so the slave also sees it on the edge where ack is high.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] r);
        int k;
        k = 0;
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'h1;
        wdat <= {24'h000000, d};
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 20);
        r = rdat[7:0];
        chkr("ack wait", 2, 2, k);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        xfer(1'b0, a, 8'h00, r);
    endtask : rd

    // Polls the status register; reading it must not clear the flag.
    task automatic wait_flag;
        logic [7:0] s;
        int         k;
        k = 0;
        do
        begin
            rd(OFS_SCR, s);
            k++;
        end
        while (s[SCR_FLAG] !== 1'b1 && k < 100);
        chk8("completion flag", 8'h80, s & 8'h80);
    endtask : wait_flag

    task automatic irq_time(output int k);
        k = 0;
        while (conv_irq !== 1'b1 && k < 1200)
        begin
            @(negedge clk);
            k++;
        end
    endtask : irq_time

    function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] r);
        case (m)
            MODE_TRUNC: fmt = {8'h00, r[9:2]};
            MODE_RIGHT: fmt = {6'h00, r};
            MODE_LEFT:  fmt = {r, 6'h00};
            default:    fmt = {~r[9], r[8:0], 6'h00};
        endcase
    endfunction : fmt

    task automatic t_reset;
        rd(OFS_SCR, q);
        chk8("status reset", 8'h1F, q);
        rd(OFS_CLK, q);
        chk8("clock reset", 8'h04, q);
        chk8("power off", 8'h01, {7'h00, power_off});
        rd(8'h10, q);
        chk8("unmapped", 8'h00, q);
    endtask : t_reset

    // Every format of one level, then a single conversion must stay single.
    task automatic t_formats;
        logic [7:0]  hi;
        logic [15:0] e;
        port_level <= 10'h2D6;
        // The first result after power-off is thrown away while the core settles.
        wr(OFS_SCR, 8'h03);
        wait_flag();
        for (int m = 0; m < 4; m++)
        begin
            wr(OFS_CLK, {4'h1, m[1:0], 2'h0});
            wr(OFS_SCR, 8'h03);
            wait_flag();
            rd(OFS_HIGH, hi);
            rd(OFS_LOW, q);
            e = fmt(m[1:0], 10'h2D6);
            chk8("result high", e[15:8], hi);
            chk8("result low", e[7:0], q);
        end
        repeat (60) @(posedge clk);
        rd(OFS_SCR, q);
        chk8("flag after read", 8'h03, q);
    endtask : t_formats

    task automatic t_channels;
        // Back to right justified from the bus clock, so the references read plainly.
        wr(OFS_CLK, 8'h14);
        for (int c = 0; c < 7; c++)
        begin
            wr(OFS_SCR, c[7:0]);
            chk8("channel", c[7:0], {3'h0, sample_channel});
            chk8("sampling", 8'h01, {7'h00, sample_enable});
            chk8("trial code", 8'h00, dac_code[9:2]);
        end
        wr(OFS_SCR, {3'h0, CH_GROUND});
        wr(OFS_SCR, {3'h0, CH_HIGH_REF});
        wait_flag();
        rd(OFS_HIGH, q);
        chk8("high reference", 8'h03, q);
        rd(OFS_LOW, q);
        chk8("high reference low", 8'hFF, q);
        wr(OFS_SCR, {3'h0, CH_GROUND});
        wait_flag();
        rd(OFS_LOW, q);
        chk8("ground", 8'h00, q);
    endtask : t_channels

    task automatic t_freeze;
        port_level <= 10'h155;
        wr(OFS_SCR, 8'h22);
        wait_flag();
        rd(OFS_HIGH, q);
        port_level <= 10'h0AA;
        repeat (80) @(posedge clk);
        rd(OFS_LOW, q);
        chk8("frozen low", 8'h55, q);
        repeat (80) @(posedge clk);
        rd(OFS_HIGH, q);
        rd(OFS_LOW, q);
        chk8("continuous low", 8'hAA, q);
        rd(OFS_SCR, q);
        chk8("flag once", 8'h22, q);
        wr(OFS_SCR, 8'h1F);
        chk8("power off", 8'h01, {7'h00, power_off});
        chk8("sampling off", 8'h00, {7'h00, sample_enable});
    endtask : t_freeze

    // Interrupt mode, then conversion length for each divider and the crystal.
    // The crystal divided by 16 gives a converter clock in the recommended band.
    task automatic t_irq;
        logic [2:0] codes [7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7, 3'h4};
        int         d;
        wr(OFS_SCR, 8'h9D);
        rd(OFS_SCR, q);
        chk8("flag read only", 8'h1D, q);
        wr(OFS_SCR, 8'hDD);
        rd(OFS_SCR, q);
        chk8("flag writable", 8'hDD, q);
        for (int i = 0; i < 7; i++)
        begin
            wr(OFS_CLK, {codes[i], (i < 6), 4'h4});
            wr(OFS_SCR, 8'h5D);
            irq_time(n);
            d = codes[i][2] ? 16 : (1 << codes[i]);
            d = (i < 6) ? d : 4 * d;
            chkr("conversion cycles", 15 * d, 17 * d + 8, n);
            rd(OFS_HIGH, q);
            chk8("irq cleared", 8'h00, {7'h00, conv_irq});
        end
    endtask : t_irq

    initial
    begin
        clk = 1'b0;
        crystal_clock = 1'b0;
        rst_n = 1'b0;
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
        port_level = 10'h000;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_formats();
        t_channels();
        t_freeze();
        t_irq();
        report_and_stop();
    end

    // Cut a hang short well beyond the expected run time.
    initial
    begin
        #2000000;
        error_cnt++;
        report_and_stop();
    end

endmodule : tb

`default_nettype wire
